// >>> bench/epi_pin_src.sv
`timescale 1ns/10ps
module epi_pin_src
  import epi_pkg::*;
#(
  parameter int HOLD = 5
)
(
  // clock
  input wire logic ref_clk,
  // pins
  output logic [EPI_N_EXT-1:0] ext_irq_pins,
  output logic [EPI_N_PC-1:0] pin_change_inputs
);
  // dedicated pins idle high, change inputs idle low
  initial begin
    ext_irq_pins = '1;
    pin_change_inputs = '0;
  end
  // every level is held for HOLD cycles, longer than the shortest pulse
  task set_ext(input int n, input logic v);
    ext_irq_pins[n] <= v;
    repeat (HOLD) @(posedge ref_clk);
  endtask : set_ext
  task tog_pc(input int i);
    pin_change_inputs[i] <= ~pin_change_inputs[i];
    repeat (HOLD) @(posedge ref_clk);
  endtask : tog_pc
endmodule : epi_pin_src

// >>> bench/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import epi_pkg::*;
;
  logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic core_irq_enable, core_sleep, wake_req, rerr;
  logic [EPI_AW-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] rdat;
  logic [EPI_N_EXT-1:0] ext_irq_pins;
  logic [EPI_N_PC-1:0] pin_change_inputs;
  epi_req_t irq_ack, irq_req;
  int miscompares = 0;
  int cmp_count = 0;

  epi_ext_irq_unit dut(.ref_clk(ref_clk), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_irq_enable(core_irq_enable), .core_sleep(core_sleep), .irq_ack(irq_ack),
    .irq_req(irq_req), .wake_req(wake_req), .ext_irq_pins(ext_irq_pins),
    .pin_change_inputs(pin_change_inputs));
  epi_pin_src src(.ref_clk(ref_clk), .ext_irq_pins(ext_irq_pins),
    .pin_change_inputs(pin_change_inputs));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one apb transfer; waits on pready, the watchdog ends a hang
  task apb(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
    @(posedge ref_clk);
    paddr <= {2'b00, idx, 2'b00};
    pwrite <= wr;
    pwdata <= {24'h000000, wd};
    psel <= 1'b1;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rdat = prdata[7:0];
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] idx, input logic [7:0] d);
    apb(idx, 1'b1, d);
  endtask : wr

  task rchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(idx, 1'b0, 8'h00);
    chk($sformatf("reg_%h", idx), exp, rdat);
  endtask : rchk

  task tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  initial begin
    tick(5000);
    miscompares++;
    print_verdict();
  end

  initial begin
    nrst = 1'b0;
    {psel, penable, pwrite, core_irq_enable, core_sleep} = '0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    irq_ack = '0;
    tick(3);
    nrst <= 1'b1;
    rchk(EPI_IDX_EXT_MASK, 8'h00);
    rchk(EPI_IDX_GRP_EN, 8'h00);
    rchk(EPI_IDX_SENSE, 8'h00);
    for (int g = 0; g < 4; g++) rchk(epi_mask_idx(g), 8'h00);
    apb(8'h00, 1'b0, 8'h00);
    chk("unmapped_err", 8'h01, {7'h00, rerr});
    wr(EPI_IDX_EXT_MASK, 8'hff);
    rchk(EPI_IDX_EXT_MASK, 8'h07);
    wr(EPI_IDX_SENSE, 8'hff);
    rchk(EPI_IDX_SENSE, 8'h3f);
    wr(EPI_IDX_EXT_MASK, 8'h00);
    $display("test registers done");
    for (int n = 0; n < 3; n++) for (int m = 1; m < 4; m++) begin
      wr(EPI_IDX_SENSE, 8'(m << (2 * n)));
      wr(EPI_IDX_EXT_FLAGS, 8'h07);
      src.set_ext(n, 1'b0);
      rchk(EPI_IDX_EXT_FLAGS, (m != 3) ? 8'(1 << n) : 8'h00);
      wr(EPI_IDX_EXT_FLAGS, 8'h07);
      src.set_ext(n, 1'b1);
      rchk(EPI_IDX_EXT_FLAGS, (m != 2) ? 8'(1 << n) : 8'h00);
    end
    $display("test sense modes done");
    wr(EPI_IDX_SENSE, 8'h20);
    wr(EPI_IDX_EXT_FLAGS, 8'h07);
    src.set_ext(2, 1'b0);
    chk("irq_req", 8'h00, {1'b0, irq_req});
    wr(EPI_IDX_EXT_MASK, 8'h04);
    tick(1);
    chk("irq_req", 8'h00, {1'b0, irq_req});
    chk("wake_req", 8'h01, {7'h00, wake_req});
    core_irq_enable <= 1'b1;
    tick(1);
    chk("irq_req", 8'h04, {1'b0, irq_req});
    irq_ack.ext <= 3'b100;
    tick(1);
    irq_ack <= '0;
    tick(1);
    chk("irq_req", 8'h00, {1'b0, irq_req});
    rchk(EPI_IDX_EXT_FLAGS, 8'h00);
    src.set_ext(2, 1'b1);
    src.set_ext(2, 1'b0);
    wr(EPI_IDX_EXT_FLAGS, 8'h00);
    rchk(EPI_IDX_EXT_FLAGS, 8'h04);
    wr(EPI_IDX_EXT_FLAGS, 8'h04);
    rchk(EPI_IDX_EXT_FLAGS, 8'h00);
    src.set_ext(2, 1'b1);
    $display("test enable and clear done");
    wr(EPI_IDX_EXT_MASK, 8'h00);
    wr(EPI_IDX_SENSE, 8'h00);
    wr(EPI_IDX_EXT_MASK, 8'h01);
    src.set_ext(0, 1'b0);
    chk("irq_req", 8'h01, {1'b0, irq_req});
    rchk(EPI_IDX_EXT_FLAGS, 8'h00);
    chk("irq_req", 8'h01, {1'b0, irq_req});
    src.set_ext(0, 1'b1);
    chk("irq_req", 8'h00, {1'b0, irq_req});
    $display("test level mode done");
    for (int g = 0; g < 4; g++) begin
      wr(EPI_IDX_GRP_EN, 8'(1 << g));
      wr(epi_mask_idx(g), 8'h80);
      rchk(epi_mask_idx(g), 8'h80);
      src.tog_pc(8 * g);
      rchk(EPI_IDX_GRP_FLAGS, 8'h00);
      src.tog_pc(8 * g + 7);
      chk("irq_req", 8'(1 << (g + 3)), {1'b0, irq_req});
      rchk(EPI_IDX_GRP_FLAGS, 8'(1 << g));
      wr(EPI_IDX_GRP_FLAGS, 8'h0f);
      rchk(EPI_IDX_GRP_FLAGS, 8'h00);
      wr(EPI_IDX_GRP_EN, 8'h00);
      src.tog_pc(8 * g + 7);
      rchk(EPI_IDX_GRP_FLAGS, 8'h00);
    end
    $display("test pin groups done");
    wr(EPI_IDX_SENSE, 8'h08);
    wr(EPI_IDX_EXT_FLAGS, 8'h07);
    core_sleep <= 1'b1;
    tick(2);
    core_sleep <= 1'b0;
    rchk(EPI_IDX_EXT_FLAGS, 8'h02);
    wr(EPI_IDX_EXT_FLAGS, 8'h07);
    wr(EPI_IDX_EXT_MASK, 8'h03);
    core_sleep <= 1'b1;
    tick(2);
    core_sleep <= 1'b0;
    rchk(EPI_IDX_EXT_FLAGS, 8'h00);
    pstrb <= 4'he;
    wr(EPI_IDX_EXT_MASK, 8'h00);
    pstrb <= 4'hf;
    rchk(EPI_IDX_EXT_MASK, 8'h03);
    $display("test sleep and strobe done");
    print_verdict();
  end
endmodule : tb_top

// >>> verilog/epi_ext_irq_unit.sv
// Design decision made here: register access over APB.
`timescale 1ns/10ps
// How it works
// - requests fire from pin levels whatever the pin direction is
// - four group requests, inputs 31:24, 23:16, 15:8, 7:0, fire on toggle
// - one eight-bit mask per group picks contributing inputs
// - change inputs give wake-up only with their mask bit and group enable set
// - dedicated pins are watched for level and edges, except disabled pins during sleep
// - enabled level-sensed pin requests for as long as it is low
// - low level gone before start-up ends gives no request
// - sense 00 low, 01 any edge, 10 falling, 11 rising
// - sense bits 7:6 read zero, fields in bits 5:0
// - dedicated request needs global enable and its mask bit
// - three enable bits 2:0, upper bits read zero
// - dedicated flag set on configured edge, request when enabled
// - flag held zero while pin is level sensed
// - sleep with pin disabled cuts its buffer, may set flag
// - four group enable bits 3:0 gate group requests
// - group flag bits 3:0 set on any change of a masked input in an enabled group
// - flags clear on acknowledge or write one; zero does nothing
// - input detects only with mask bit and group enable set
module epi_ext_irq_unit
  import epi_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // apb slave
  input wire logic [EPI_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core side
  input wire logic core_irq_enable,
  input wire logic core_sleep,
  input wire epi_req_t irq_ack,
  output epi_req_t irq_req,
  output logic wake_req,
  // pins
  input wire logic [EPI_N_EXT-1:0] ext_irq_pins,
  input wire logic [EPI_N_PC-1:0] pin_change_inputs
);

  logic [EPI_N_EXT-1:0] ext_s1_reg;
  logic [EPI_N_EXT-1:0] ext_s2_reg;
  logic [EPI_N_EXT-1:0] ext_d_reg;
  logic [EPI_N_PC-1:0] pc_s1_reg;
  logic [EPI_N_PC-1:0] pc_s2_reg;
  logic [EPI_N_PC-1:0] pc_d_reg;
  logic [EPI_N_EXT-1:0] ext_en_reg;
  logic [EPI_N_GRP-1:0] grp_en_reg;
  logic [EPI_SENSE_W-1:0] sense_reg;
  logic [EPI_N_GRP-1:0][EPI_GRP_W-1:0] pc_mask_reg;
  logic [EPI_N_EXT-1:0] ext_flag_reg;
  logic [EPI_N_GRP-1:0] grp_flag_reg;
  logic [31:0] prdata_reg;
  logic err_reg;
  logic [31:0] rd_next;
  logic err_next;
  logic wr_en;
  logic [EPI_N_EXT-1:0] ext_int;
  logic [EPI_N_EXT-1:0] ext_lvl;
  logic [EPI_N_EXT-1:0] ext_hit;
  logic [EPI_N_EXT-1:0] ext_clr;
  logic [EPI_N_PC-1:0] pc_chg;
  logic [EPI_N_GRP-1:0] grp_hit;
  logic [EPI_N_GRP-1:0] grp_clr;

  function automatic logic sense_hit(input epi_sense_t s, input logic cur,
                                     input logic prev);
    logic r;
    r = 1'b0;
    unique case (s)
      EPI_SENSE_LOW: r = 1'b0;
      EPI_SENSE_ANY: r = cur ^ prev;
      EPI_SENSE_FALL: r = prev & ~cur;
      EPI_SENSE_RISE: r = cur & ~prev;
    endcase
    return r;
  endfunction : sense_hit

  function automatic logic at(input logic [EPI_AW-1:0] a, input logic [7:0] idx);
    return a == epi_addr(idx);
  endfunction : at

  // pin synchronisers; pins are sampled as they are, output or not
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ext_s1_reg <= '0;
      ext_s2_reg <= '0;
      pc_s1_reg <= '0;
      pc_s2_reg <= '0;
    end else begin
      ext_s1_reg <= ext_irq_pins;
      ext_s2_reg <= ext_s1_reg;
      pc_s1_reg <= pin_change_inputs;
      pc_s2_reg <= pc_s1_reg;
    end
  end

  // buffer of a disabled pin reads low during sleep
  assign ext_int = ext_s2_reg & ~({EPI_N_EXT{core_sleep}} & ~ext_en_reg);

  // previous samples for edge and change detection
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ext_d_reg <= '0;
      pc_d_reg <= '0;
    end else begin
      ext_d_reg <= ext_int;
      pc_d_reg <= pc_s2_reg;
    end
  end

  always_comb begin
    for (int i = 0; i < EPI_N_EXT; i++) begin
      ext_lvl[i] = epi_sense_t'(sense_reg[2*i +: 2]) == EPI_SENSE_LOW;
      ext_hit[i] = sense_hit(epi_sense_t'(sense_reg[2*i +: 2]), ext_int[i],
                             ext_d_reg[i]);
    end
  end

  assign pc_chg = pc_s2_reg ^ pc_d_reg;

  always_comb begin
    for (int g = 0; g < EPI_N_GRP; g++) begin
      grp_hit[g] = grp_en_reg[g] &
                   (|(pc_chg[g*EPI_GRP_W +: EPI_GRP_W] & pc_mask_reg[g]));
    end
  end

  // apb write strobe; only byte lane 0 carries register bits
  assign wr_en = psel & penable & pwrite & pstrb[0];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ext_en_reg <= EPI_RST_BYTE[EPI_N_EXT-1:0];
    end else if (wr_en && at(paddr, EPI_IDX_EXT_MASK)) begin
      ext_en_reg <= pwdata[EPI_N_EXT-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      grp_en_reg <= EPI_RST_BYTE[EPI_N_GRP-1:0];
    end else if (wr_en && at(paddr, EPI_IDX_GRP_EN)) begin
      grp_en_reg <= pwdata[EPI_N_GRP-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sense_reg <= EPI_RST_BYTE[EPI_SENSE_W-1:0];
    end else if (wr_en && at(paddr, EPI_IDX_SENSE)) begin
      sense_reg <= pwdata[EPI_SENSE_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pc_mask_reg <= '0;
    end else begin
      for (int g = 0; g < EPI_N_GRP; g++) begin
        if (wr_en && at(paddr, epi_mask_idx(g))) begin
          pc_mask_reg[g] <= pwdata[EPI_GRP_W-1:0];
        end
      end
    end
  end

  // flag clears from write-one and from core acknowledge
  assign ext_clr = irq_ack.ext | ((wr_en && at(paddr, EPI_IDX_EXT_FLAGS)) ?
                   pwdata[EPI_N_EXT-1:0] : '0);
  assign grp_clr = irq_ack.grp | ((wr_en && at(paddr, EPI_IDX_GRP_FLAGS)) ?
                   pwdata[EPI_N_GRP-1:0] : '0);

  // a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ext_flag_reg <= '0;
    end else begin
      for (int i = 0; i < EPI_N_EXT; i++) begin
        if (ext_lvl[i]) begin
          ext_flag_reg[i] <= 1'b0;
        end else if (ext_hit[i]) begin
          ext_flag_reg[i] <= 1'b1;
        end else if (ext_clr[i]) begin
          ext_flag_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      grp_flag_reg <= '0;
    end else begin
      for (int g = 0; g < EPI_N_GRP; g++) begin
        if (grp_hit[g]) begin
          grp_flag_reg[g] <= 1'b1;
        end else if (grp_clr[g]) begin
          grp_flag_reg[g] <= 1'b0;
        end
      end
    end
  end

  // level requests follow the live pin, so a level gone early requests nothing
  always_comb begin
    for (int i = 0; i < EPI_N_EXT; i++) begin
      irq_req.ext[i] = core_irq_enable & ext_en_reg[i] &
                       (ext_lvl[i] ? ~ext_int[i] : ext_flag_reg[i]);
    end
    irq_req.grp = {EPI_N_GRP{core_irq_enable}} & grp_en_reg & grp_flag_reg;
  end

  // wake does not wait for the global enable
  assign wake_req = |(ext_en_reg & ((ext_lvl & ~ext_int) | ext_flag_reg)) |
                    |(grp_en_reg & grp_flag_reg);

  always_comb begin
    rd_next = '0;
    err_next = 1'b0;
    case (paddr)
      epi_addr(EPI_IDX_EXT_MASK): rd_next[EPI_N_EXT-1:0] = ext_en_reg;
      epi_addr(EPI_IDX_GRP_EN): rd_next[EPI_N_GRP-1:0] = grp_en_reg;
      epi_addr(EPI_IDX_SENSE): rd_next[EPI_SENSE_W-1:0] = sense_reg;
      epi_addr(EPI_IDX_EXT_FLAGS): rd_next[EPI_N_EXT-1:0] = ext_flag_reg;
      epi_addr(EPI_IDX_GRP_FLAGS): rd_next[EPI_N_GRP-1:0] = grp_flag_reg;
      epi_addr(EPI_IDX_MASK0): rd_next[EPI_GRP_W-1:0] = pc_mask_reg[0];
      epi_addr(EPI_IDX_MASK1): rd_next[EPI_GRP_W-1:0] = pc_mask_reg[1];
      epi_addr(EPI_IDX_MASK2): rd_next[EPI_GRP_W-1:0] = pc_mask_reg[2];
      epi_addr(EPI_IDX_MASK3): rd_next[EPI_GRP_W-1:0] = pc_mask_reg[3];
      default: err_next = 1'b1;
    endcase
  end

  // read data and error are captured in the setup cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_reg <= '0;
      err_reg <= 1'b0;
    end else if (psel && !penable) begin
      prdata_reg <= pwrite ? '0 : rd_next;
      err_reg <= err_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = psel & penable & err_reg;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  property p_level_req;
    ext_en_reg[0] && core_irq_enable && ext_lvl[0] && !ext_int[0]
      |-> irq_req.ext[0];
  endproperty
  a_level_req: assert property (p_level_req)
    else $error("level request missing while pin low");

  property p_level_flag;
    ext_lvl[1] && $past(ext_lvl[1]) |-> !ext_flag_reg[1];
  endproperty
  a_level_flag: assert property (p_level_flag)
    else $error("flag set while level sensed");

  property p_fall_flag;
    epi_sense_t'(sense_reg[1:0]) == EPI_SENSE_FALL && ext_d_reg[0] && !ext_int[0]
      |=> ext_flag_reg[0];
  endproperty
  a_fall_flag: assert property (p_fall_flag)
    else $error("falling edge did not set flag");

  property p_rise_only;
    epi_sense_t'(sense_reg[5:4]) == EPI_SENSE_RISE && !ext_flag_reg[2] &&
      !(ext_int[2] && !ext_d_reg[2]) |=> !ext_flag_reg[2];
  endproperty
  a_rise_only: assert property (p_rise_only)
    else $error("flag set without rising edge");

  property p_gie_gate;
    !core_irq_enable |-> irq_req == '0;
  endproperty
  a_gie_gate: assert property (p_gie_gate)
    else $error("request without global enable");

  property p_grp_set;
    grp_en_reg[3] && pc_mask_reg[3][7] && $changed(pc_s2_reg[31])
      |=> grp_flag_reg[3];
  endproperty
  a_grp_set: assert property (p_grp_set)
    else $error("group change did not set flag");

  property p_grp_off;
    !grp_en_reg[0] && !grp_flag_reg[0] |=> !grp_flag_reg[0];
  endproperty
  a_grp_off: assert property (p_grp_off)
    else $error("disabled group set its flag");

  property p_pin_to_req;
    core_irq_enable && grp_en_reg[1] && pc_mask_reg[1][7] && !grp_flag_reg[1] &&
      $changed(pc_s1_reg[15]) ##1 (grp_en_reg[1] && core_irq_enable)[*2]
      |-> irq_req.grp[1];
  endproperty
  a_pin_to_req: assert property (p_pin_to_req)
    else $error("group request late after input toggle");

  property p_w1c;
    wr_en && at(paddr, EPI_IDX_GRP_FLAGS) && pwdata[2] && !grp_hit[2]
      |=> !grp_flag_reg[2];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write one did not clear flag");

  property p_ack;
    irq_ack.ext[2] && !ext_hit[2] |=> !ext_flag_reg[2];
  endproperty
  a_ack: assert property (p_ack)
    else $error("acknowledge did not clear flag");

  property p_sleep_buf;
    core_sleep && !ext_en_reg[1] |-> !ext_int[1];
  endproperty
  a_sleep_buf: assert property (p_sleep_buf)
    else $error("disabled pin buffer not cut in sleep");

  property p_sense_read;
    psel && !penable && !pwrite && at(paddr, EPI_IDX_SENSE)
      |=> prdata_reg[31:EPI_SENSE_W] == '0 && prdata_reg[5:0] == $past(sense_reg);
  endproperty
  a_sense_read: assert property (p_sense_read)
    else $error("sense read wrong");

  property p_mask_read;
    psel && !penable && !pwrite && at(paddr, EPI_IDX_EXT_MASK)
      |=> prdata_reg == {29'h0, $past(ext_en_reg)};
  endproperty
  a_mask_read: assert property (p_mask_read)
    else $error("enable mask read wrong");

  property p_ext_w1c;
    wr_en && at(paddr, EPI_IDX_EXT_FLAGS) && pwdata[2] && !ext_hit[2]
      |=> !ext_flag_reg[2];
  endproperty
  a_ext_w1c: assert property (p_ext_w1c)
    else $error("write one did not clear pin flag");

  property p_ext_req;
    ext_flag_reg[2] && ext_en_reg[2] && core_irq_enable && !ext_lvl[2]
      |-> irq_req.ext[2];
  endproperty
  a_ext_req: assert property (p_ext_req)
    else $error("pending enabled pin flag gave no request");

  property p_strobe;
    psel && penable && pwrite && !pstrb[0]
      |=> ext_en_reg == $past(ext_en_reg);
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("write without lane 0 strobe changed enable mask");

  c_level: cover property (irq_req.ext[0] && ext_lvl[0]);
  c_edge: cover property (ext_hit[2] ##1 irq_req.ext[2]);
  c_group: cover property (grp_hit[3] ##1 irq_req.grp[3]);
  c_err: cover property (pslverr);

endmodule : epi_ext_irq_unit

// >>> verilog/epi_pkg.sv
package epi_pkg;

  localparam int unsigned EPI_N_EXT = 3;
  localparam int unsigned EPI_N_GRP = 4;
  localparam int unsigned EPI_GRP_W = 8;
  localparam int unsigned EPI_N_PC = 32;
  localparam int unsigned EPI_AW = 12;

  // register indexes; byte address is four times the index
  localparam logic [7:0] EPI_IDX_EXT_MASK = 8'h1d;
  localparam logic [7:0] EPI_IDX_GRP_EN = 8'h68;
  localparam logic [7:0] EPI_IDX_MASK0 = 8'h6b;
  localparam logic [7:0] EPI_IDX_MASK1 = 8'h6c;
  localparam logic [7:0] EPI_IDX_MASK2 = 8'h6d;
  localparam logic [7:0] EPI_IDX_MASK3 = 8'h73;
  localparam logic [7:0] EPI_IDX_SENSE = 8'h20;
  localparam logic [7:0] EPI_IDX_EXT_FLAGS = 8'h21;
  localparam logic [7:0] EPI_IDX_GRP_FLAGS = 8'h22;

  localparam logic [7:0] EPI_RST_BYTE = 8'h00;
  localparam int unsigned EPI_SENSE_W = 6;

  typedef enum logic [1:0] {
    EPI_SENSE_LOW = 2'b00,
    EPI_SENSE_ANY = 2'b01,
    EPI_SENSE_FALL = 2'b10,
    EPI_SENSE_RISE = 2'b11
  } epi_sense_t;

  typedef struct packed {
    logic [3:0] grp;
    logic [2:0] ext;
  } epi_req_t;

  function automatic logic [EPI_AW-1:0] epi_addr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : epi_addr

  function automatic logic [7:0] epi_mask_idx(input int unsigned g);
    logic [7:0] r;
    r = EPI_IDX_MASK0;
    case (g)
      1: r = EPI_IDX_MASK1;
      2: r = EPI_IDX_MASK2;
      3: r = EPI_IDX_MASK3;
      default: r = EPI_IDX_MASK0;
    endcase
    return r;
  endfunction : epi_mask_idx

endpackage : epi_pkg
